// ---- include/arw_pkg.sv ----
// package for the converter result accumulate and window block
// assumes a 50 MHz ref_clk and a 32-bit AXI4-Lite register bus
`default_nettype none
package arw_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned POWERUP_TIME_NS = 1000;
  // least time, so round up
  localparam int unsigned POWERUP_CYCLES  =
    (POWERUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned SAMPLE_W = 10;
  localparam int unsigned ACC_W    = 16;
  localparam int unsigned MAX_REPEAT = 64;
  localparam int unsigned LEFT_SHIFT = ACC_W - SAMPLE_W;

  // register byte addresses
  localparam logic [7:0] OFS_CONTROL       = 8'h00;
  localparam logic [7:0] OFS_ACCUM_CFG     = 8'h04;
  localparam logic [7:0] OFS_RESULT_HIGH   = 8'h08;
  localparam logic [7:0] OFS_RESULT_LOW    = 8'h0C;
  localparam logic [7:0] OFS_GREATER_HIGH  = 8'h10;
  localparam logic [7:0] OFS_GREATER_LOW   = 8'h14;
  localparam logic [7:0] OFS_LESS_HIGH     = 8'h18;
  localparam logic [7:0] OFS_LESS_LOW      = 8'h1C;
  localparam logic [7:0] OFS_SAR_DIVIDER   = 8'h20;
  localparam logic [7:0] OFS_POWER_CFG     = 8'h24;
  localparam logic [7:0] OFS_TRACKING_CFG  = 8'h28;

  // control register bit positions
  localparam int unsigned CTL_POWER_ON = 0;
  localparam int unsigned CTL_BURST    = 1;
  localparam int unsigned CTL_DONE     = 2;
  localparam int unsigned CTL_BUSY     = 3;
  localparam int unsigned CTL_WINDOW   = 4;
  localparam int unsigned CTL_START    = 5;

  // accumulate config fields
  localparam int unsigned FMT_LSB = 0;
  localparam int unsigned FMT_W   = 3;
  localparam int unsigned RPT_LSB = 3;
  localparam int unsigned RPT_W   = 3;

  localparam logic [2:0] FMT_RIGHT = 3'h0;
  localparam logic [2:0] FMT_LEFT  = 3'h4;

  // repeat codes: 0 one sample, 1..5 four to sixty-four samples
  localparam logic [2:0] RPT_1  = 3'h0;
  localparam logic [2:0] RPT_4  = 3'h1;
  localparam logic [2:0] RPT_8  = 3'h2;
  localparam logic [2:0] RPT_16 = 3'h3;
  localparam logic [2:0] RPT_32 = 3'h4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    ARW_IDLE,
    ARW_POWERUP,
    ARW_CONVERT,
    ARW_FINISH
  } arw_state_e;

  typedef struct packed {
    logic [ACC_W-1:0] greater;
    logic [ACC_W-1:0] less;
  } arw_limits_s;

  typedef struct packed {
    logic                valid;
    logic [SAMPLE_W-1:0] data;
  } arw_sample_s;

endpackage
`default_nettype wire

// ---- hw/arw_accum.sv ----
// accumulator and result formatter
// assumes samples arrive on ref_clk from the conversion core
`default_nettype none
module arw_accum
  import arw_pkg::*;
(
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  // control
  input  wire logic                clear,
  input  wire arw_sample_s         sample,
  input  wire logic [FMT_W-1:0]    format,
  // formatted view of the running sum
  output logic      [ACC_W-1:0]    formatted
);

  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] acc_next;
  logic [ACC_W-1:0] sample_wide;
  logic [ACC_W-1:0] left_view;
  logic [ACC_W-1:0] right_view;

  assign sample_wide = {{(ACC_W-SAMPLE_W){1'b0}}, sample.data};
  // 64 ten-bit samples fit exactly, so the sum never wraps
  assign acc_next = clear ? sample_wide : ACC_W'(acc_reg + sample_wide);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_reg <= '0;
    end else if (sample.valid) begin
      acc_reg <= acc_next;
    end
  end

  // left view suits one sample only; low bits fill with zero
  assign left_view  = ACC_W'(acc_reg << LEFT_SHIFT);
  assign right_view = acc_reg >> format[1:0];
  assign formatted  = format[FMT_W-1] ? left_view : right_view;

endmodule
`default_nettype wire

// ---- hw/arw_window.sv ----
// window comparator on the formatted result word
// combinational; the caller registers the match
`default_nettype none
module arw_window
  import arw_pkg::*;
(
  // compared word and limits
  input  wire logic [ACC_W-1:0] result,
  input  wire arw_limits_s      limits,
  // condition met
  output logic                  match
);

  logic above_greater;
  logic below_less;
  logic inside_mode;

  assign above_greater = result > limits.greater;
  assign below_less    = result < limits.less;
  assign inside_mode   = limits.less > limits.greater;
  assign match = inside_mode ? (above_greater & below_less)
                             : (above_greater | below_less);

endmodule
`default_nettype wire

// ---- hw/arw_top.sv ----
// converter back end: burst sequencing, accumulate, format, window detect
// assumes the conversion core runs on ref_clk and answers each sample request
// with one sample_valid pulse; software reaches registers over AXI4-Lite
//
// Behaviour
// - burst start accumulates the programmed number of samples, at most 64
// - finished result lands in a high byte and a low byte register
// - format 000 is right-justified, 100 left-justified for one sample
// - one 10-bit sample gives an unsigned code from 0 to 1023
// - result bits not used by the formatted code read zero
// - multi-sample sums reach the result registers only after the last sample
// - repeat count offers 4, 8, 16, 32 or 64 summed unsigned samples
// - samples sum in a 16-bit accumulator that the format then shapes
// - format can shift the sum right by one, two or three bits
// - window detector compares each new result against two limits
// - greater and less limits are each a high and low byte pair
// - relative limit values choose inside or outside window detection
// - less above greater: flag when greater < result < less
// - window flag is a pollable status bit and an event output
// - burst powers the core up once, then runs all its conversions
// - done flag sets per conversion or per burst and holds until cleared
`default_nettype none
module arw_top
  import arw_pkg::*;
#(
  parameter int unsigned POWERUP_CYC = POWERUP_CYCLES
)(
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  // axi4-lite write address and data
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // axi4-lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // external conversion start pin
  input  wire logic                ext_start,
  // conversion core
  input  wire logic                sample_valid,
  input  wire logic [SAMPLE_W-1:0] sample_data,
  output logic                     core_power,
  output logic                     core_sample_req,
  output logic [7:0]               core_divider,
  output logic [7:0]               core_power_cfg,
  output logic [7:0]               core_tracking_cfg,
  // status
  output logic                     conversion_done_flag,
  output logic                     window_compare_flag,
  output logic                     window_event
);

  arw_state_e state_reg, state_next;

  logic [31:0]      ctl_reg;
  logic             power_on_reg, burst_reg, done_reg, window_reg;
  logic [FMT_W-1:0] format_reg;
  logic [RPT_W-1:0] repeat_reg;
  logic [7:0]       res_high_reg, res_low_reg;
  logic [7:0]       gt_high_reg, gt_low_reg, lt_high_reg, lt_low_reg;
  logic [7:0]       divider_reg, power_cfg_reg, tracking_cfg_reg;
  logic [15:0]      pwr_cnt_reg;
  logic [6:0]       left_reg;
  logic             req_reg, event_reg, start_sw_reg;
  logic             ext_meta_reg, ext_sync_reg, ext_prev_reg;

  // axi4-lite slave
  logic        aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
  logic        awready_reg, wready_reg, arready_reg;
  logic [7:0]  waddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0]  wstrb_reg;
  logic [1:0]  bresp_reg, rresp_reg;

  wire aw_take  = s_axi_awvalid & awready_reg;
  wire w_take   = s_axi_wvalid & wready_reg;
  wire aw_have  = aw_held_reg | aw_take;
  wire w_have   = w_held_reg | w_take;
  wire [7:0]  wa = aw_held_reg ? waddr_reg : s_axi_awaddr;
  wire [31:0] wd = w_held_reg ? wdata_reg : s_axi_wdata;
  wire [3:0]  ws = w_held_reg ? wstrb_reg : s_axi_wstrb;
  wire wr_fire  = aw_have & w_have & ~bvalid_reg;
  wire wr_lane0 = wr_fire & ws[0];
  wire ar_take  = s_axi_arvalid & arready_reg;
  wire [7:0]  ra = s_axi_araddr;

  wire wr_ctl   = wr_lane0 & (wa == OFS_CONTROL);
  wire wr_acfg  = wr_lane0 & (wa == OFS_ACCUM_CFG);
  wire wr_gth   = wr_lane0 & (wa == OFS_GREATER_HIGH);
  wire wr_gtl   = wr_lane0 & (wa == OFS_GREATER_LOW);
  wire wr_lth   = wr_lane0 & (wa == OFS_LESS_HIGH);
  wire wr_ltl   = wr_lane0 & (wa == OFS_LESS_LOW);
  wire wr_div   = wr_lane0 & (wa == OFS_SAR_DIVIDER);
  wire wr_pwr   = wr_lane0 & (wa == OFS_POWER_CFG);
  wire wr_trk   = wr_lane0 & (wa == OFS_TRACKING_CFG);
  wire wa_known = (wa <= OFS_TRACKING_CFG) & (wa[1:0] == 2'b00);
  wire ra_known = (ra <= OFS_TRACKING_CFG) & (ra[1:0] == 2'b00);

  wire done_clr   = wr_ctl & wd[CTL_DONE];
  wire window_clr = wr_ctl & wd[CTL_WINDOW];
  wire sw_start   = wr_ctl & wd[CTL_START];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      waddr_reg   <= BYTE_ZERO;
      wdata_reg   <= WORD_ZERO;
      wstrb_reg   <= 4'h0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (aw_take) waddr_reg <= s_axi_awaddr;
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      aw_held_reg <= aw_have & ~wr_fire;
      w_held_reg  <= w_have & ~wr_fire;
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wa_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // registers written by software
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      power_on_reg     <= 1'b0;
      burst_reg        <= 1'b0;
      format_reg       <= FMT_RIGHT;
      repeat_reg       <= RPT_1;
      gt_high_reg      <= BYTE_ZERO;
      gt_low_reg       <= BYTE_ZERO;
      lt_high_reg      <= BYTE_ZERO;
      lt_low_reg       <= BYTE_ZERO;
      divider_reg      <= BYTE_ZERO;
      power_cfg_reg    <= BYTE_ZERO;
      tracking_cfg_reg <= BYTE_ZERO;
    end else begin
      if (wr_ctl) begin
        power_on_reg <= wd[CTL_POWER_ON];
        burst_reg    <= wd[CTL_BURST];
      end
      if (wr_acfg) begin
        format_reg <= wd[FMT_LSB +: FMT_W];
        repeat_reg <= wd[RPT_LSB +: RPT_W];
      end
      if (wr_gth) gt_high_reg <= wd[7:0];
      if (wr_gtl) gt_low_reg  <= wd[7:0];
      if (wr_lth) lt_high_reg <= wd[7:0];
      if (wr_ltl) lt_low_reg  <= wd[7:0];
      if (wr_div) divider_reg <= wd[7:0];
      if (wr_pwr) power_cfg_reg <= wd[7:0];
      if (wr_trk) tracking_cfg_reg <= wd[7:0];
    end
  end

  // start sources
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
      start_sw_reg <= 1'b0;
    end else begin
      ext_meta_reg <= ext_start;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
      start_sw_reg <= sw_start;
    end
  end

  wire start_any  = start_sw_reg | (ext_sync_reg & ~ext_prev_reg);
  // a start while busy is dropped on purpose
  wire start_take = start_any & (state_reg == ARW_IDLE);

  // sample count per start
  logic [6:0] count_sel;
  assign count_sel = !burst_reg        ? 7'd1 :
                     (repeat_reg == RPT_1)  ? 7'd1  :
                     (repeat_reg == RPT_4)  ? 7'd4  :
                     (repeat_reg == RPT_8)  ? 7'd8  :
                     (repeat_reg == RPT_16) ? 7'd16 :
                     (repeat_reg == RPT_32) ? 7'd32 : 7'(MAX_REPEAT);

  // always-on keeps the core powered: no warm-up
  wire need_powerup = ~power_on_reg;
  wire pwr_done     = (pwr_cnt_reg == 16'(POWERUP_CYC - 1));
  wire last_sample  = sample_valid & (left_reg == 7'd1);
  wire first_sample = (left_reg == count_sel);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ARW_IDLE:    if (start_take) state_next = need_powerup ? ARW_POWERUP : ARW_CONVERT;
      ARW_POWERUP: if (pwr_done) state_next = ARW_CONVERT;
      ARW_CONVERT: if (last_sample) state_next = ARW_FINISH;
      ARW_FINISH:  state_next = ARW_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg   <= ARW_IDLE;
      pwr_cnt_reg <= 16'h0000;
      left_reg    <= 7'd0;
      req_reg     <= 1'b0;
    end else begin
      state_reg   <= state_next;
      pwr_cnt_reg <= (state_reg == ARW_POWERUP) ? pwr_cnt_reg + 16'h0001 : 16'h0000;
      if (start_take) left_reg <= count_sel;
      else if (sample_valid && state_reg == ARW_CONVERT) left_reg <= left_reg - 7'd1;
      // one request per sample, each answered before the next
      req_reg <= (state_next == ARW_CONVERT) &
                 ((state_reg != ARW_CONVERT) | (sample_valid & ~last_sample));
    end
  end

  // accumulate and format
  arw_sample_s samp;
  logic [ACC_W-1:0] formatted;
  assign samp.valid = sample_valid & (state_reg == ARW_CONVERT);
  assign samp.data  = sample_data;

  arw_accum u_accum (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .clear     (first_sample),
    .sample    (samp),
    .format    (format_reg),
    .formatted (formatted)
  );

  // result registers and flags
  arw_limits_s limits;
  logic        match;
  assign limits.greater = {gt_high_reg, gt_low_reg};
  assign limits.less    = {lt_high_reg, lt_low_reg};

  arw_window u_window (
    .result (ACC_W'({res_high_reg, res_low_reg})),
    .limits (limits),
    .match  (match)
  );

  wire result_load = (state_reg == ARW_FINISH);
  logic res_new_reg;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      res_high_reg <= BYTE_ZERO;
      res_low_reg  <= BYTE_ZERO;
      res_new_reg  <= 1'b0;
      done_reg     <= 1'b0;
      window_reg   <= 1'b0;
      event_reg    <= 1'b0;
    end else begin
      if (result_load) begin
        res_high_reg <= formatted[15:8];
        res_low_reg  <= formatted[7:0];
      end
      res_new_reg <= result_load;
      // set wins over a clear in the same cycle
      done_reg   <= result_load | (done_reg & ~done_clr);
      window_reg <= (res_new_reg & match) | (window_reg & ~window_clr);
      event_reg  <= res_new_reg & match;
    end
  end

  // read path
  always_comb begin
    ctl_reg = WORD_ZERO;
    ctl_reg[CTL_POWER_ON] = power_on_reg;
    ctl_reg[CTL_BURST]    = burst_reg;
    ctl_reg[CTL_DONE]     = done_reg;
    ctl_reg[CTL_BUSY]     = (state_reg != ARW_IDLE);
    ctl_reg[CTL_WINDOW]   = window_reg;
  end

  logic [31:0] rd_mux;
  assign rd_mux =
    (ra == OFS_CONTROL)      ? ctl_reg :
    (ra == OFS_ACCUM_CFG)    ? {26'h0, repeat_reg, format_reg} :
    (ra == OFS_RESULT_HIGH)  ? {24'h0, res_high_reg} :
    (ra == OFS_RESULT_LOW)   ? {24'h0, res_low_reg} :
    (ra == OFS_GREATER_HIGH) ? {24'h0, gt_high_reg} :
    (ra == OFS_GREATER_LOW)  ? {24'h0, gt_low_reg} :
    (ra == OFS_LESS_HIGH)    ? {24'h0, lt_high_reg} :
    (ra == OFS_LESS_LOW)     ? {24'h0, lt_low_reg} :
    (ra == OFS_SAR_DIVIDER)  ? {24'h0, divider_reg} :
    (ra == OFS_POWER_CFG)    ? {24'h0, power_cfg_reg} :
    (ra == OFS_TRACKING_CFG) ? {24'h0, tracking_cfg_reg} : WORD_ZERO;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= WORD_ZERO;
      rresp_reg  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= ra_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // outputs
  logic power_out_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      awready_reg   <= 1'b0;
      wready_reg    <= 1'b0;
      arready_reg   <= 1'b0;
      power_out_reg <= 1'b0;
    end else begin
      awready_reg   <= ~aw_have & ~wr_fire & ~(bvalid_reg & ~s_axi_bready);
      wready_reg    <= ~w_have & ~wr_fire & ~(bvalid_reg & ~s_axi_bready);
      arready_reg   <= ~ar_take & ~(rvalid_reg & ~s_axi_rready);
      power_out_reg <= power_on_reg | (state_next != ARW_IDLE);
    end
  end

  // ready is registered and qualified again by the take terms
  assign s_axi_awready        = awready_reg;
  assign s_axi_wready         = wready_reg;
  assign s_axi_arready        = arready_reg;
  assign s_axi_bvalid         = bvalid_reg;
  assign s_axi_bresp          = bresp_reg;
  assign s_axi_rvalid         = rvalid_reg;
  assign s_axi_rdata          = rdata_reg;
  assign s_axi_rresp          = rresp_reg;
  assign core_power           = power_out_reg;
  assign core_sample_req      = req_reg;
  assign core_divider         = divider_reg;
  assign core_power_cfg       = power_cfg_reg;
  assign core_tracking_cfg    = tracking_cfg_reg;
  assign conversion_done_flag = done_reg;
  assign window_compare_flag  = window_reg;
  assign window_event         = event_reg;

endmodule
`default_nettype wire

// ---- sim/arw_top_props.sv ----
// concurrent checks on the arw_top ports, bound into every arw_top
// assumes one clock domain with the synchronous active-low reset
`default_nettype none
module arw_top_props
  import arw_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // register bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // core and status
  input wire logic        core_power,
  input wire logic        core_sample_req,
  input wire logic        conversion_done_flag,
  input wire logic        window_compare_flag,
  input wire logic        window_event
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // no write data for two cycles, so no clear pending
  sequence quiet_bus;
    !s_axi_wvalid ##1 !s_axi_wvalid;
  endsequence

  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  bad_write_a: assert property (wr_taken ##0 (s_axi_awaddr > 8'h28) |=>
    s_axi_bvalid && s_axi_bresp == RESP_SLVERR) else $error("unmapped write accepted");
  bad_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h28
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == WORD_ZERO)
    else $error("unmapped read accepted");
  req_pulse_a: assert property (core_sample_req |=> !core_sample_req)
    else $error("request too long");
  req_powered_a: assert property (core_sample_req |-> core_power)
    else $error("request while unpowered");
  done_sticky_a: assert property (quiet_bus ##0 conversion_done_flag |=>
    conversion_done_flag) else $error("done flag fell");
  window_sticky_a: assert property (quiet_bus ##0 window_compare_flag |=>
    window_compare_flag) else $error("window flag fell");
  event_flag_a: assert property (window_event |-> window_compare_flag)
    else $error("event without flag");
endmodule

bind arw_top arw_top_props chk_u (.*);
`default_nettype wire

// ---- sim/arw_core_model.sv ----
// behavioural conversion core: one sample per request after a set delay
// assumes requests are single-cycle pulses on ref_clk
`default_nettype none
module arw_core_model
  import arw_pkg::*;
(
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  // request and bench settings
  input  wire logic                core_sample_req,
  input  wire logic [SAMPLE_W-1:0] value,
  input  wire logic [3:0]          delay,
  // answer
  output logic                     sample_valid,
  output logic [SAMPLE_W-1:0]      sample_data
);
  logic [4:0] wait_reg;

  // data toggles between pulses so stale data never matches
  always_ff @(posedge ref_clk) begin
    sample_valid <= 1'b0;
    sample_data  <= ~sample_data;
    if (!rst_n) begin
      wait_reg    <= 5'h0;
      sample_data <= '0;
    end else if (core_sample_req) begin
      wait_reg <= {1'b0, delay} + 5'h1;
    end else if (wait_reg == 5'h1) begin
      wait_reg     <= 5'h0;
      sample_valid <= 1'b1;
      sample_data  <= value;
    end else if (wait_reg != 5'h0) begin
      wait_reg <= wait_reg - 5'h1;
    end
  end
endmodule
`default_nettype wire

// ---- sim/adc_result_accumulate_window_bench.sv ----
// testbench for arw_top: axi4-lite master tasks, one task per scenario
// assumes arw_pkg, arw_top, arw_top_props and arw_core_model compiled first
`default_nettype none
module adc_result_accumulate_window_bench
  import arw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                ref_clk, rst_n, ext_start, sample_valid, core_sample_req, core_power;
  logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                s_axi_rvalid, s_axi_rready, conversion_done_flag;
  logic                window_compare_flag, window_event;
  logic [7:0]          s_axi_awaddr, s_axi_araddr, core_divider, core_power_cfg;
  logic [7:0]          core_tracking_cfg;
  logic [31:0]         s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]          s_axi_wstrb, core_delay;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  logic [SAMPLE_W-1:0] sample_data, core_value;
  int                  n_errors, n_tests;

  arw_top #(.POWERUP_CYC(2)) dut_u (.*);
  arw_core_model core_u (.*, .value(core_value), .delay(core_delay));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_d = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_d = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    @(posedge ref_clk);
    s_axi_bready <= 1'b0;
    check("bresp", 32'(s_axi_bresp), 32'(er));
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [1:0] er = RESP_OKAY);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge ref_clk);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    check("rresp", 32'(s_axi_rresp), 32'(er));
  endtask

  // clears both flags with the start
  task automatic run(input logic [31:0] ctl, input logic [SAMPLE_W-1:0] v,
                     input logic [3:0] dly, input logic ext);
    int k;
    core_value <= v;
    core_delay <= dly;
    wr(OFS_CONTROL, ctl | (ext ? 32'h14 : 32'h34));
    check("done cleared", 32'(conversion_done_flag), 32'h0);
    if (ext) begin
      ext_start <= 1'b1;
      repeat (4) @(posedge ref_clk);
      ext_start <= 1'b0;
    end
    k = 0;
    while (conversion_done_flag !== 1'b1 && k < 3000) begin
      @(posedge ref_clk);
      k++;
    end
    check("done set", 32'(conversion_done_flag), 32'h1);
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic res(input string what, input logic [15:0] exp);
    rd_reg(OFS_RESULT_HIGH);
    check(what, rd, {24'h0, exp[15:8]});
    rd_reg(OFS_RESULT_LOW);
    check(what, rd, {24'h0, exp[7:0]});
  endtask

  task automatic t_bus;
    rd_reg(OFS_TRACKING_CFG);
    check("tracking reset", rd, WORD_ZERO);
    wr(8'h30, 32'hFF, RESP_SLVERR);
    rd_reg(8'h2C, RESP_SLVERR);
    check("unmapped read", rd, WORD_ZERO);
    wr(OFS_SAR_DIVIDER, 32'h1);
    wr(OFS_POWER_CFG, 32'h40);
    wr(OFS_TRACKING_CFG, 32'hBF);
    check("tracking out", 32'(core_tracking_cfg), 32'hBF);
    check("cfg out", 32'({core_divider, core_power_cfg}), 32'h0140);
    $display("test bus done");
  endtask

  task automatic t_single;
    wr(OFS_ACCUM_CFG, 32'(FMT_RIGHT));
    run(32'h1, 10'h3FF, 4'h0, 1'b0);
    res("right full", 16'h03FF);
    wr(OFS_ACCUM_CFG, 32'(FMT_LEFT));
    run(32'h1, 10'h200, 4'h3, 1'b0);
    res("left half", 16'h8000);
    run(32'h1, 10'h100, 4'h2, 1'b1);
    res("pin start", 16'h4000);
    $display("test single done");
  endtask

  task automatic t_burst;
    for (int c = 1; c <= 5; c++) begin
      wr(OFS_ACCUM_CFG, 32'(c << RPT_LSB));
      run(32'h2, 10'h3FF, 4'(c), 1'b0);
      res("burst sum", 16'h03FF << (c + 1));
    end
    for (int s = 1; s <= 3; s++) begin
      wr(OFS_ACCUM_CFG, 32'(8 | s));
      run(32'h2, 10'h3FF, 4'h0, 1'b0);
      res("shifted sum", 16'h0FFC >> s);
    end
    wr(OFS_ACCUM_CFG, 32'h28);
    run(32'h2, 10'h3FF, 4'h0, 1'b0);
    wr(OFS_ACCUM_CFG, 32'h2B);
    fork
      run(32'h2, 10'h3FF, 4'hF, 1'b0);
      begin
        repeat (20) @(posedge ref_clk);
        rd_reg(OFS_RESULT_LOW);
        check("mid burst", rd, 32'hC0);
      end
    join
    res("shift three", 16'h1FF8);
    $display("test burst done");
  endtask

  task automatic lim(input logic [15:0] g, input logic [15:0] l);
    wr(OFS_GREATER_HIGH, 32'(g[15:8]));
    wr(OFS_GREATER_LOW, 32'(g[7:0]));
    wr(OFS_LESS_HIGH, 32'(l[15:8]));
    wr(OFS_LESS_LOW, 32'(l[7:0]));
  endtask

  task automatic win(input logic [SAMPLE_W-1:0] v, input logic exp);
    run(32'h1, v, 4'h1, 1'b0);
    check("window flag", 32'(window_compare_flag), 32'(exp));
    rd_reg(OFS_CONTROL);
    check("window bit", 32'(rd[CTL_WINDOW]), 32'(exp));
  endtask

  task automatic t_window;
    wr(OFS_ACCUM_CFG, 32'(FMT_RIGHT));
    lim(16'h0040, 16'h0080);
    win(10'h060, 1'b1);
    win(10'h040, 1'b0);
    lim(16'h0080, 16'h0040);
    win(10'h090, 1'b1);
    win(10'h060, 1'b0);
    wr(OFS_ACCUM_CFG, 32'(FMT_LEFT));
    win(10'h001, 1'b0);
    win(10'h003, 1'b1);
    $display("test window done");
  endtask

  initial begin
    n_errors = 0;
    n_tests = 0;
    {rst_n, ext_start, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    core_value = '0;
    core_delay = '0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_bus;
    t_single;
    t_burst;
    t_window;
    end_sim;
  end

  // whole run is well under 20k cycles
  initial begin
    #1_000_000;
    n_errors++;
    $display("timeout");
    end_sim;
  end
endmodule
`default_nettype wire
